// ==== rtl/efp_pkg.sv ====
// Shared constants and types of the earth fault protection stages.
package efp_pkg;
   // ****************************************************************
   // Sizes and timing.
   // ****************************************************************
   localparam int NS = 4;
   localparam int CUR_W = 20;
   localparam int HIST_DEPTH = 64;
   localparam int TICK_MS = 5;
   localparam int PRE_TRIG_MS = 20;
   localparam int PRE_FAULT_MS = 200;
   localparam int PRE_TRIG_SMP = PRE_TRIG_MS / TICK_MS;
   localparam int PRE_FAULT_SMP = PRE_FAULT_MS / TICK_MS;
   localparam logic [19:0] PICKUP_RST = 20'h02ee0;
   localparam logic [12:0] HARM_LIM_RST = 13'h0001;
   localparam logic [15:0] OP_DLY_RST = 16'h0014;
   localparam logic [15:0] RST_DLY_RST = 16'h0000;
   localparam logic [26:0] FULL_PCT = 27'h0000064;
   localparam logic [26:0] RESET_PCT = 27'h0000061;

   // ****************************************************************
   // Register offsets and field positions.
   // ****************************************************************
   localparam logic [7:0] GLOBAL_BASE = 8'h80;
   localparam logic [4:0] OFS_CFG = 5'h00;
   localparam logic [4:0] OFS_PICK = 5'h04;
   localparam logic [4:0] OFS_DLY = 5'h08;
   localparam logic [4:0] OFS_STAT = 5'h0c;
   localparam logic [4:0] OFS_RATIO = 5'h10;
   localparam logic [4:0] OFS_CNT = 5'h14;
   localparam logic [7:0] OFS_GCTRL = 8'h80;
   localparam logic [7:0] OFS_FAULT = 8'h84;
   localparam logic [7:0] OFS_LOGSEL = 8'h88;
   localparam logic [7:0] OFS_ANGLE = 8'h8c;
   localparam logic [7:0] OFS_LOGD0 = 8'h90;
   localparam int CFG_IDMT = 0;
   localparam int CFG_HARM = 1;
   localparam int CFG_HLIM = 16;
   localparam int DLY_RST = 16;
   localparam int STAT_REM = 16;
   localparam int CNT_TRIP = 10;
   localparam int CNT_BLK = 20;
   localparam int GC_EV_ON = 2;
   localparam int GC_EV_OFF = 3;
   localparam int GC_CLR = 8;

   // ****************************************************************
   // Types.
   // ****************************************************************
   typedef enum logic [1:0] {COND_NORMAL, COND_START, COND_TRIP, COND_BLOCKED} efp_cond_e;
   typedef enum logic [1:0] {SEL_COARSE, SEL_SENS, SEL_CALC} efp_insel_e;
   typedef enum logic [2:0] {FT_NONE, FT_A_R, FT_B_F, FT_C_R, FT_A_F, FT_B_R, FT_C_F} efp_fault_e;
   typedef enum logic [1:0] {EV_START, EV_TRIP, EV_BLOCK} efp_evkind_e;

   typedef struct packed {
      logic idmt;
      logic harm_en;
      logic [12:0] harm_lim;
      logic [19:0] pickup;
      logic [15:0] op_dly;
      logic [15:0] rst_dly;
   } efp_cfg_s;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } efp_wb_req_s;

   typedef struct packed {
      logic stb;
      logic [19:0] coarse;
      logic [19:0] sens;
      logic [19:0] calc;
      logic [12:0] harm;
      logic signed [15:0] ang_i0;
      logic signed [15:0] ang_u1;
      logic signed [15:0] ang_i1;
      logic volt_ok;
      logic [1:0] phase;
      logic fwd;
   } efp_meas_s;

   typedef struct packed {
      logic valid;
      logic [1:0] stage;
      efp_evkind_e kind;
      logic on;
      logic [31:0] stamp;
   } efp_event_s;

   typedef struct packed {
      logic [31:0] stamp;
      logic [1:0] stage;
      efp_evkind_e kind;
      efp_fault_e ftype;
      logic [19:0] pre_trig;
      logic [19:0] fault_cur;
      logic [19:0] pre_fault;
      logic [15:0] remain;
      logic [2:0] group;
   } efp_log_s;
endpackage : efp_pkg

// ==== rtl/efp_mem.sv ====
// Small single write, single read memory with registered read data.
`timescale 1ns/1ps
`default_nettype none
module efp_mem #(
   parameter int W = 8,
   parameter int D = 16
) (
   input wire logic sys_clk_i,
   input wire logic we_i,
   input wire logic [$clog2(D)-1:0] waddr_i,
   input wire logic [W-1:0] wdata_i,
   input wire logic [$clog2(D)-1:0] raddr_i,
   output logic [W-1:0] rdata_o
);
   logic [W-1:0] mem [D];

   // Write port and registered read port; storage needs no reset.
   always_ff @(posedge sys_clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end
endmodule : efp_mem
`default_nettype wire

// ==== rtl/efp_stage.sv ====
// One protection stage: pick-up, blocking, operate and release timing.
`timescale 1ns/1ps
`default_nettype none
module efp_stage (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic stb_i,
   input wire logic blk_i,
   input wire logic [19:0] cur_i,
   input wire logic [12:0] harm_i,
   input wire efp_pkg::efp_cfg_s cfg_i,
   output efp_pkg::efp_cond_e cond_o,
   output logic [15:0] remain_o,
   output logic [19:0] ratio_o
);
   typedef struct packed {
      efp_pkg::efp_cond_e cond;
      logic pick;
      logic [15:0] elapsed;
      logic [15:0] rel;
      logic [15:0] remain;
      logic [19:0] ratio;
   } efp_stage_st_s;

   efp_stage_st_s q;
   efp_stage_st_s n;

   // Next state, advanced once per processing cycle strobe; the remaining time is recomputed every clock.
   always_comb begin
      logic pk;
      logic blk;
      logic [15:0] expt;
      logic [35:0] quo;
      logic [26:0] rq;
      n = q;
      pk = q.pick;
      if (cur_i > cfg_i.pickup) begin
         pk = 1'b1;
      end else if (27'(cur_i) * efp_pkg::FULL_PCT < 27'(cfg_i.pickup) * efp_pkg::RESET_PCT) begin
         pk = 1'b0;
      end
      blk = blk_i || (cfg_i.harm_en && harm_i > cfg_i.harm_lim);
      quo = '1;
      if (cur_i > cfg_i.pickup) begin
         quo = (36'(cfg_i.op_dly) * 36'(cfg_i.pickup)) / 36'(cur_i - cfg_i.pickup);
      end
      expt = cfg_i.op_dly;
      if (cfg_i.idmt) begin
         expt = (quo > 36'(16'hffff)) ? 16'hffff : quo[15:0];
      end
      rq = (cfg_i.pickup == 20'h00000) ? '1 : (27'(cur_i) * efp_pkg::FULL_PCT) / 27'(cfg_i.pickup);
      if (stb_i) begin
         n.pick = pk;
         n.ratio = (rq > 27'(20'hfffff)) ? 20'hfffff : rq[19:0];
         case (q.cond)
            efp_pkg::COND_NORMAL: begin
               if (q.rel != 16'h0000) begin
                  n.rel = q.rel - 16'h0001;
               end else begin
                  n.elapsed = 16'h0000;
               end
               if (pk && blk) begin
                  n.cond = efp_pkg::COND_BLOCKED;
               end else if (pk) begin
                  n.cond = efp_pkg::COND_START;
                  n.rel = 16'h0000;
                  n.elapsed = (q.rel != 16'h0000) ? q.elapsed : 16'h0000;
               end
            end
            efp_pkg::COND_START: begin
               if (!pk || blk) begin
                  n.cond = efp_pkg::COND_NORMAL;
                  n.rel = cfg_i.rst_dly;
               end else begin
                  n.elapsed = q.elapsed + 16'h0001;
                  if (q.elapsed + 16'h0001 >= expt) begin
                     n.cond = efp_pkg::COND_TRIP;
                  end
               end
            end
            efp_pkg::COND_TRIP: begin
               if (!pk) begin
                  n.cond = efp_pkg::COND_NORMAL;
                  n.elapsed = 16'h0000;
                  n.rel = 16'h0000;
               end
            end
            efp_pkg::COND_BLOCKED: begin
               if (!pk) begin
                  n.cond = efp_pkg::COND_NORMAL;
               end
            end
            default: begin
               n.cond = efp_pkg::COND_NORMAL;
            end
         endcase
      end
      n.remain = 16'h0000;
      if (n.cond == efp_pkg::COND_START && expt > n.elapsed) begin
         n.remain = expt - n.elapsed;
      end
   end

   // State register.
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign cond_o = q.cond;
   assign remain_o = q.remain;
   assign ratio_o = q.ratio;
endmodule : efp_stage
`default_nettype wire

// ==== rtl/efp_earth_fault.sv ====
// Four earth fault protection stages with events, counters, log and Wishbone registers.
//
// The register addresses and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module efp_earth_fault #(
   parameter int LOG_DEPTH = 12
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire efp_pkg::efp_wb_req_s wb_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   input wire efp_pkg::efp_meas_s meas_i,
   input wire logic ext_block_i,
   input wire logic [2:0] set_group_i,
   input wire logic [31:0] timestamp_i,
   output efp_pkg::efp_event_s event_o,
   output logic [3:0] start_o,
   output logic [3:0] trip_o,
   output logic [3:0] blocked_o
);
   // ****************************************************************
   // Elaboration check and types.
   // ****************************************************************
   if (LOG_DEPTH < 1 || LOG_DEPTH > 16) begin : g_bad_depth
      $error("LOG_DEPTH must lie between 1 and 16");
   end

   localparam int LA_W = $clog2(efp_pkg::NS * LOG_DEPTH);
   localparam int LOG_W = $bits(efp_pkg::efp_log_s);

   typedef struct packed {
      efp_pkg::efp_cfg_s [3:0] cfg;
      efp_pkg::efp_insel_e insel;
      logic ev_on;
      logic ev_off;
      logic [5:0] logsel;
      logic [3:0][2:0][9:0] cnt;
      logic [3:0][2:0] lvl;
      logic [3:0][2:0][1:0] pend;
      logic [3:0][3:0] wptr;
      efp_pkg::efp_fault_e ftype;
      logic signed [16:0] angle;
      logic [19:0] cur;
      logic [12:0] harm;
      logic blk;
      logic stb;
      logic [5:0] hptr;
      logic ack;
      logic [31:0] dat;
      efp_pkg::efp_event_s ev;
      logic lwe;
      logic [LA_W-1:0] lwa;
      efp_pkg::efp_log_s lwd;
   } efp_top_st_s;

   efp_top_st_s q;
   efp_top_st_s n;

   efp_pkg::efp_cond_e cond [4];
   logic [15:0] remain [4];
   logic [19:0] ratio [4];
   logic [19:0] pre_trig;
   logic [19:0] pre_fault;
   logic [LOG_W-1:0] log_rd;
   logic [LA_W-1:0] log_ra;

   // ****************************************************************
   // Helper functions.
   // ****************************************************************

   // Merges a bus write into a word under its byte enables.
   function automatic logic [31:0] efp_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction : efp_merge

   // Maps faulted phase and direction onto the reported fault type.
   function automatic efp_pkg::efp_fault_e efp_ftype(input logic [1:0] ph, input logic fwd);
      case (ph)
         2'h0: efp_ftype = fwd ? efp_pkg::FT_A_F : efp_pkg::FT_A_R;
         2'h1: efp_ftype = fwd ? efp_pkg::FT_B_F : efp_pkg::FT_B_R;
         2'h2: efp_ftype = fwd ? efp_pkg::FT_C_F : efp_pkg::FT_C_R;
         default: efp_ftype = efp_pkg::FT_NONE;
      endcase
   endfunction : efp_ftype

   // Log slot of a stage entry, counted back from the newest one.
   function automatic logic [LA_W-1:0] efp_slot(input logic [1:0] s, input logic [3:0] wp,
                                                input logic [3:0] back);
      int x;
      x = (int'(wp) + 2 * LOG_DEPTH - 1 - int'(back) % LOG_DEPTH) % LOG_DEPTH;
      return LA_W'(int'(s) * LOG_DEPTH + x);
   endfunction : efp_slot

   // Configuration word as software reads it.
   function automatic logic [31:0] efp_cfg_word(input efp_pkg::efp_cfg_s c);
      logic [31:0] w;
      w = '0;
      w[efp_pkg::CFG_IDMT] = c.idmt;
      w[efp_pkg::CFG_HARM] = c.harm_en;
      w[efp_pkg::CFG_HLIM +: 13] = c.harm_lim;
      return w;
   endfunction : efp_cfg_word

   // ****************************************************************
   // Stages, history and log memories.
   // ****************************************************************
   for (genvar s = 0; s < efp_pkg::NS; s++) begin : g_stage
      efp_stage u_stage (
         .sys_clk_i(sys_clk_i),
         .nrst_i(nrst_i),
         .stb_i(q.stb),
         .blk_i(q.blk),
         .cur_i(q.cur),
         .harm_i(q.harm),
         .cfg_i(q.cfg[s]),
         .cond_o(cond[s]),
         .remain_o(remain[s]),
         .ratio_o(ratio[s])
      );
   end

   efp_mem #(.W(efp_pkg::CUR_W), .D(efp_pkg::HIST_DEPTH)) u_hist_trig (
      .sys_clk_i(sys_clk_i),
      .we_i(q.stb),
      .waddr_i(q.hptr),
      .wdata_i(q.cur),
      .raddr_i(q.hptr - 6'(efp_pkg::PRE_TRIG_SMP + 1)), // Pointer is one past the newest sample.
      .rdata_o(pre_trig)
   );

   efp_mem #(.W(efp_pkg::CUR_W), .D(efp_pkg::HIST_DEPTH)) u_hist_fault (
      .sys_clk_i(sys_clk_i),
      .we_i(q.stb),
      .waddr_i(q.hptr),
      .wdata_i(q.cur),
      .raddr_i(q.hptr - 6'(efp_pkg::PRE_FAULT_SMP + 1)),
      .rdata_o(pre_fault)
   );

   assign log_ra = efp_slot(q.logsel[5:4], q.wptr[q.logsel[5:4]], q.logsel[3:0]);

   efp_mem #(.W(LOG_W), .D(efp_pkg::NS * LOG_DEPTH)) u_log (
      .sys_clk_i(sys_clk_i),
      .we_i(q.lwe),
      .waddr_i(q.lwa),
      .wdata_i(q.lwd),
      .raddr_i(log_ra),
      .rdata_o(log_rd)
   );

   // ****************************************************************
   // Next state of the whole block.
   // ****************************************************************
   always_comb begin
      logic [23:0] popm;
      logic [23:0] setm;
      logic hit;
      logic now;
      logic [4:0] ps;
      logic [1:0] pk;
      logic [1:0] st;
      logic [127:0] lw;
      logic [31:0] rd;
      logic [31:0] wv;
      efp_pkg::efp_cfg_s c;
      popm = '0;
      setm = '0;
      hit = 1'b0;
      now = 1'b0;
      ps = '0;
      pk = '0;
      st = '0;
      lw = 128'(log_rd);
      rd = '0;
      wv = '0;
      c = '0;
      n = q;
      n.ack = 1'b0;
      n.stb = 1'b0;
      n.lwe = 1'b0;
      n.ev.valid = 1'b0;

      // Latch the selected residual, harmonic and blocking at cycle start.
      if (meas_i.stb) begin
         case (q.insel)
            efp_pkg::SEL_COARSE: n.cur = meas_i.coarse;
            efp_pkg::SEL_SENS: n.cur = meas_i.sens;
            default: n.cur = meas_i.calc;
         endcase
         n.harm = meas_i.harm;
         n.blk = ext_block_i;
         n.stb = 1'b1;
      end
      if (q.stb) begin
         n.hptr = q.hptr + 6'h01;
      end

      // Residual angle against voltage, or current when no voltage exists.
      n.angle = 17'(meas_i.ang_i0) - (meas_i.volt_ok ? 17'(meas_i.ang_u1)
                                                     : 17'(meas_i.ang_i1));

      // Edge detection on each stage output, one ON and one OFF flag each.
      for (int s = 0; s < efp_pkg::NS; s++) begin
         for (int k = 0; k < 3; k++) begin
            case (k)
               0: now = cond[s] == efp_pkg::COND_START || cond[s] == efp_pkg::COND_TRIP;
               1: now = cond[s] == efp_pkg::COND_TRIP;
               default: now = cond[s] == efp_pkg::COND_BLOCKED;
            endcase
            n.lvl[s][k] = now;
            if (now != q.lvl[s][k]) begin
               setm[s * 6 + k * 2 + int'(now)] = 1'b1;
            end
         end
      end

      // Serialise one pending event per cycle, lowest index first.
      for (int i = 0; i < 24; i++) begin
         if (!hit && q.pend[i / 6][(i % 6) / 2][i % 2]) begin
            hit = 1'b1;
            popm[i] = 1'b1;
            ps = 5'(i);
         end
      end
      st = 2'(ps / 5'h06);
      pk = 2'((ps % 5'h06) / 5'h02);
      if (hit) begin
         n.ev.valid = ps[0] ? q.ev_on : q.ev_off;
         n.ev.stage = st;
         n.ev.kind = efp_pkg::efp_evkind_e'(pk);
         n.ev.on = ps[0];
         n.ev.stamp = timestamp_i;
         if (ps[0]) begin
            n.lwe = 1'b1;
            n.lwa = LA_W'(int'(st) * LOG_DEPTH + int'(q.wptr[st]));
            n.wptr[st] = (q.wptr[st] == 4'(LOG_DEPTH - 1)) ? 4'h0 : q.wptr[st] + 4'h1;
            n.lwd.stamp = timestamp_i;
            n.lwd.stage = st;
            n.lwd.kind = efp_pkg::efp_evkind_e'(pk);
            n.lwd.ftype = q.ftype;
            n.lwd.pre_trig = pre_trig;
            n.lwd.fault_cur = q.cur;
            n.lwd.pre_fault = pre_fault;
            n.lwd.remain = remain[st];
            n.lwd.group = set_group_i;
         end
      end
      n.pend = (q.pend & ~popm) | setm;

      // Fault type follows each new start.
      for (int s = 0; s < efp_pkg::NS; s++) begin
         if (setm[s * 6 + 1]) begin
            n.ftype = efp_ftype(meas_i.phase, meas_i.fwd);
         end
      end

      // Wishbone slave: one wait-free cycle, ack the cycle after the request.
      if (wb_i.cyc && wb_i.stb && !q.ack) begin
         n.ack = 1'b1;
         st = wb_i.adr[6:5];
         c = q.cfg[st];
         if (wb_i.adr < efp_pkg::GLOBAL_BASE) begin
            case (wb_i.adr[4:0])
               efp_pkg::OFS_CFG: rd = efp_cfg_word(c);
               efp_pkg::OFS_PICK: rd = 32'(c.pickup);
               efp_pkg::OFS_DLY: rd = {c.rst_dly, c.op_dly};
               efp_pkg::OFS_STAT: rd = {remain[st], 14'h0000, cond[st]};
               efp_pkg::OFS_RATIO: rd = 32'(ratio[st]);
               efp_pkg::OFS_CNT: rd = 32'({q.cnt[st][2], q.cnt[st][1], q.cnt[st][0]});
               default: rd = '0;
            endcase
            if (wb_i.we) begin
               case (wb_i.adr[4:0])
                  efp_pkg::OFS_CFG: begin
                     wv = efp_merge(rd, wb_i.dat, wb_i.sel);
                     c.idmt = wv[efp_pkg::CFG_IDMT];
                     c.harm_en = wv[efp_pkg::CFG_HARM];
                     c.harm_lim = wv[efp_pkg::CFG_HLIM +: 13];
                  end
                  efp_pkg::OFS_PICK: begin
                     wv = efp_merge(rd, wb_i.dat, wb_i.sel);
                     c.pickup = wv[19:0];
                  end
                  efp_pkg::OFS_DLY: {c.rst_dly, c.op_dly} = efp_merge(rd, wb_i.dat, wb_i.sel);
                  default: c = q.cfg[st];
               endcase
               n.cfg[st] = c;
            end
         end else begin
            case (wb_i.adr)
               efp_pkg::OFS_GCTRL: rd = {28'h0000000, q.ev_off, q.ev_on, q.insel};
               efp_pkg::OFS_FAULT: rd = 32'(q.ftype);
               efp_pkg::OFS_LOGSEL: rd = 32'(q.logsel);
               efp_pkg::OFS_ANGLE: rd = 32'(q.angle);
               efp_pkg::OFS_LOGD0: rd = lw[31:0];
               efp_pkg::OFS_LOGD0 + 8'h04: rd = lw[63:32];
               efp_pkg::OFS_LOGD0 + 8'h08: rd = lw[95:64];
               efp_pkg::OFS_LOGD0 + 8'h0c: rd = lw[127:96];
               default: rd = '0;
            endcase
            if (wb_i.we) begin
               wv = efp_merge(rd, wb_i.dat, wb_i.sel);
               if (wb_i.adr == efp_pkg::OFS_GCTRL) begin
                  n.insel = efp_pkg::efp_insel_e'(wv[1:0]);
                  n.ev_on = wv[efp_pkg::GC_EV_ON];
                  n.ev_off = wv[efp_pkg::GC_EV_OFF];
                  if (wb_i.sel[1] && wb_i.dat[efp_pkg::GC_CLR]) begin
                     n.cnt = '0;
                  end
               end else if (wb_i.adr == efp_pkg::OFS_LOGSEL) begin
                  n.logsel = wv[5:0];
               end
            end
         end
         n.dat = rd;
      end

      // Counters count ON edges; a count in the clearing cycle survives.
      for (int s = 0; s < efp_pkg::NS; s++) begin
         for (int k = 0; k < 3; k++) begin
            if (setm[s * 6 + k * 2 + 1]) begin
               n.cnt[s][k] = n.cnt[s][k] + 10'h001;
            end
         end
      end
   end

   // ****************************************************************
   // State register and outputs.
   // ****************************************************************
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q <= '0;
         for (int s = 0; s < efp_pkg::NS; s++) begin
            q.cfg[s].pickup <= efp_pkg::PICKUP_RST;
            q.cfg[s].harm_lim <= efp_pkg::HARM_LIM_RST;
            q.cfg[s].op_dly <= efp_pkg::OP_DLY_RST;
            q.cfg[s].rst_dly <= efp_pkg::RST_DLY_RST;
         end
         q.ev_on <= 1'b1;
         q.ev_off <= 1'b1;
      end else begin
         q <= n;
      end
   end

   // Outputs drive direct control and user logic straight from flops.
   always_comb begin
      wb_ack_o = q.ack;
      wb_dat_o = q.dat;
      event_o = q.ev;
      for (int s = 0; s < efp_pkg::NS; s++) begin
         start_o[s] = q.lvl[s][0];
         trip_o[s] = q.lvl[s][1];
         blocked_o[s] = q.lvl[s][2];
      end
   end
endmodule : efp_earth_fault
`default_nettype wire

// ==== testbench/efp_chk.sv ====
// Bus and stage state checks bound to the earth fault block.
`timescale 1ns/1ps
`default_nettype none
module efp_chk (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire efp_pkg::efp_wb_req_s wb_i,
   input wire logic wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire efp_pkg::efp_meas_s meas_i,
   input wire logic [3:0] start_o,
   input wire logic [3:0] trip_o,
   input wire logic [3:0] blocked_o
);
   default clocking dc @(posedge sys_clk_i);
   endclocking
   default disable iff (!nrst_i);
   // A request that has not been answered yet.
   sequence s_req;
      wb_i.cyc && wb_i.stb && !wb_ack_o;
   endsequence
   a_ack_next: assert property (s_req |=> wb_ack_o) else $error("no ack");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
   a_ack_idle: assert property (!wb_i.cyc |=> !wb_ack_o) else $error("stray ack");
   a_dat_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("data moved");
   a_trip_start: assert property ((trip_o & ~start_o) == 4'h0)
      else $error("trip alone");
   a_blk_excl: assert property ((blocked_o & start_o) == 4'h0)
      else $error("blocked and start");
   a_out_tick: assert property (!$stable({start_o, trip_o, blocked_o}) |-> $past(meas_i.stb, 3))
      else $error("off tick");
   a_trip_prev: assert property ($rose(trip_o[0]) |-> $past(start_o[0]))
      else $error("trip skipped start");
endmodule : efp_chk
bind efp_earth_fault efp_chk u_chk (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .wb_i(wb_i),
   .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .meas_i(meas_i), .start_o(start_o),
   .trip_o(trip_o), .blocked_o(blocked_o));
`default_nettype wire

// ==== testbench/efp_meas_model.sv ====
// Measurement channels and blocking matrix feeding one tick every few cycles.
`timescale 1ns/1ps
`default_nettype none
module efp_meas_model #(
   parameter int PERIOD = 4
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic [19:0] cur_i,
   input wire logic blk_i,
   output var efp_pkg::efp_meas_s meas_o,
   output logic ext_block_o
);
   logic [3:0] cnt_q;
   // Free running tick counter.
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) cnt_q <= 4'h0;
      else cnt_q <= (cnt_q == 4'(PERIOD - 1)) ? 4'h0 : cnt_q + 4'h1;
   end
   // One strobe per tick; unused channels read zero so a wrong select shows.
   always_comb begin
      meas_o = '0;
      meas_o.stb = (cnt_q == 4'h1) && nrst_i;
      meas_o.coarse = cur_i;
      ext_block_o = blk_i;
   end
endmodule : efp_meas_model
`default_nettype wire

// ==== testbench/efp_earth_fault_tb.sv ====
// Self-checking bench for the earth fault stage block.
`timescale 1ns/1ps
`default_nettype none
module efp_earth_fault_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic blk = 1'b0;
   logic ack, ext_blk;
   logic [19:0] cur = 20'h0;
   logic [31:0] rd, dat;
   logic [3:0] st, tr, bl;
   efp_pkg::efp_wb_req_s wb = '0;
   efp_pkg::efp_meas_s meas;
   efp_pkg::efp_event_s ev;
   int n_ev = 0;
   int failures = 0;
   int total_checks = 0;
   efp_earth_fault dut (.sys_clk_i(clk), .nrst_i(rst_n), .wb_i(wb), .wb_ack_o(ack),
      .wb_dat_o(dat), .meas_i(meas), .ext_block_i(ext_blk), .set_group_i(3'h1),
      .timestamp_i(32'h0), .event_o(ev), .start_o(st), .trip_o(tr), .blocked_o(bl));
   efp_meas_model u_src (.sys_clk_i(clk), .nrst_i(rst_n), .cur_i(cur), .blk_i(blk),
      .meas_o(meas), .ext_block_o(ext_blk));
   // Clock at 100 ns period.
   initial begin
      forever #50 clk = ~clk;
   end
   // Counts the ON events that reach the event output.
   always @(posedge clk) begin
      if (ev.valid && ev.on) n_ev <= n_ev + 1;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic test_done;
      if (failures == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : test_done
   task automatic tmo;
      failures++;
      test_done();
   endtask : tmo
   // One classic cycle; held until ack is seen at a rising edge.
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
      wb <= '{1'b1, 1'b1, we, 4'hf, a, d};
      @(posedge clk);
      for (int i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk);
      if (ack !== 1'b1) tmo();
      rd = dat;
      wb <= '0;
      @(posedge clk);
   endtask : bus
   // Waits for n ticks, then until the outputs have settled.
   task automatic tk(input int n);
      repeat (n) begin
         @(posedge clk);
         for (int i = 0; i < 8 && meas.stb !== 1'b1; i++) @(posedge clk);
         if (meas.stb !== 1'b1) tmo();
      end
      repeat (3) @(posedge clk);
   endtask : tk
   // Default level, live setting change and an unmapped read.
   task automatic s_reg;
      bus(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h2ee0);
      bus(1'b1, 8'h04, 32'h3e8);
      bus(1'b1, 8'h08, 32'h2);
      bus(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h3e8);
      bus(1'b0, 8'h78, 32'h0);
      chk(rd, 32'h0);
   endtask : s_reg
   // Equal level, timed trip on the second tick, release at the ratio edge.
   task automatic s_trip;
      cur <= 20'h3e8;
      tk(1);
      chk(32'(st), 32'h0);
      cur <= 20'h3e9;
      tk(1);
      chk(32'({st, tr}), 32'h10);
      tk(1);
      chk(32'(tr), 32'h0);
      tk(1);
      chk(32'(tr), 32'h1);
      bus(1'b0, 8'h0c, 32'h0);
      chk(32'(rd[1:0]), 32'h2);
      cur <= 20'h3ca;
      tk(1);
      chk(32'(st), 32'h1);
      cur <= 20'h3c9;
      tk(1);
      chk(32'({st, tr}), 32'h0);
   endtask : s_trip
   // Blocking before pick-up, then blocking that arrives after start.
   task automatic s_blk;
      blk <= 1'b1;
      cur <= 20'h3e9;
      tk(1);
      chk(32'({st, bl}), 32'h1);
      blk <= 1'b0;
      cur <= 20'h0;
      tk(1);
      cur <= 20'h3e9;
      tk(1);
      blk <= 1'b1;
      tk(1);
      chk(32'(st), 32'h0);
      cur <= 20'h0;
      tk(1);
   endtask : s_blk
   // Main sequence: reset, scenarios, counters and their clear.
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      s_reg();
      s_trip();
      s_blk();
      bus(1'b0, 8'h14, 32'h0);
      chk(32'(rd[19:0]), 32'h402);
      bus(1'b1, 8'h80, 32'h10c);
      bus(1'b0, 8'h14, 32'h0);
      chk(rd, 32'h0);
      chk(32'(n_ev), 32'h4);
      test_done();
   end
endmodule : efp_earth_fault_tb
`default_nettype wire
